/* File: logic/tbac_core.sv */
// Token bus access core: station parameters, timers, sort delays, transmitter.
// Assumes a classic Wishbone master and a MAC user on clk_i, PHY rx on a pin.
//
// Operation
// - Init copies every station parameter to working set
// - Own transmissions never count as heard traffic
// - All conditions evaluated together each cycle
// - Frame 8191 octets, data unit capped
// - Pass counters stop at half address plus one
// - Access classes up to 6, -2 maintenance
// - Fault count seven means failed transmitter
// - Symbol from rate, octet eight symbols
// - Slot time one octet up to 8191
// - Solicit count maximum between 16 and 255
// - Retry limit 0 to 7, typically 3
// - High priority hold time 16-bit unsigned
// - Rotation targets per class, 21-bit range
// - Timers count down, expired at zero
// - Frame control octet class, type, action, priority
// - Claim data unit 0,2,4,6 slot times
// - Bus idle limit 6 lowest, else 7
// - Response delay 0 below holder, else 1
// - Contention delay is complemented address pair
// - Symbol stream out, optional checksum omission
// - Four pending queues, one-entry response queue
// - Six distinct line symbols
// - Claim pass counter steps at the start of each claim
`timescale 1ns/1ps
module tbac_core
	import tbac_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Register bus
	input wire tbac_wb_s wb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// MAC user
	input wire logic [3:0] pend_i,
	input wire logic rsp_push_i,
	input wire logic [7:0] tx_oct_i,
	output logic tx_take_o,
	output logic rsp_full_o,
	// Physical layer
	input wire logic [2:0] phy_rx_i,
	output tbac_sym_e phy_tx_o
);

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic on;
		logic [15:0] ista;
		logic [12:0] islot;
		logic [7:0] isol;
		logic [2:0] iret;
		logic [15:0] ihold;
		logic [3:0][20:0] itrt;
		logic [20:0] irmt;
		logic iring;
		logic [15:0] sta;
		logic [12:0] slot;
		logic [7:0] sol;
		logic [2:0] ret;
		logic [15:0] hold;
		logic [3:0][20:0] trt;
		logic [20:0] rmt;
		logic ring;
		logic low;
		logic under;
		logic omit;
		logic [3:0] gran;
		logic [3:0][20:0] tmr;
		logic [7:0] div;
		logic [2:0] symn;
		logic [12:0] slotn;
		logic [4:0] ccnt;
		logic [4:0] kcnt;
		logic [2:0] fault;
		logic [7:0] fc;
		logic [12:0] txlen;
		tbac_tx_e tx;
		logic claim;
		logic [2:0] bitn;
		logic [15:0] left;
		logic [7:0] sh;
		logic [31:0] crc;
		tbac_sym_e sym;
		logic rsp;
		logic [2:0] r1;
		logic [2:0] r2;
		logic [2:0] r3;
		logic heard;
		logic last;
		logic [2:0] own;
	} tbac_st_s;

	function automatic tbac_st_s rst_val();
		tbac_st_s v;
		v = '0;
		v.islot = SLOT_MIN;
		v.isol = SOL_MIN;
		v.iret = RETRY_RST;
		v.slot = SLOT_MIN;
		v.sol = SOL_MIN;
		v.ret = RETRY_RST;
		v.tx = TX_IDLE;
		v.sym = SYM_SIL;
		v.r1 = SYM_SIL;
		v.r2 = SYM_SIL;
		v.r3 = SYM_SIL;
		return v;
	endfunction

	localparam tbac_st_s RST = rst_val();

	function automatic logic [31:0] bmerge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = n[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Address bit pair picked by a sort cycle, most significant pair first
	function automatic logic [1:0] apair(logic [15:0] a, logic [4:0] c);
		logic [2:0] i;
		i = 3'(ADDR_PAIRS - 1) - c[2:0];
		if (c >= 5'(ADDR_PAIRS)) begin
			return 2'h0;
		end
		return a[{i, 1'b0} +: 2];
	endfunction

	tbac_st_s q;
	tbac_st_s d;
	tbac_fc_s fcv;
	logic take;
	logic sgo;
	logic cgo;
	logic req;
	logic wr;
	logic symt;
	logic octt;
	logic slott;
	logic [3:0] tt;
	logic [3:0] tw;
	logic [3:0] texp;
	logic [31:0] rv;
	logic [31:0] wd;
	logic [31:0] ncrc;
	logic [2:0] cs;
	logic [1:0] cont;
	logic [2:0] idle;
	logic rdly;
	logic [15:0] clen;

	////////////////////////////////////////////////////////////////////////////
	// Symbol, octet and slot ticks
	assign symt = q.div == SYM_LAST;
	assign octt = symt && q.symn == 3'(OCT_SYMS - 1);
	assign slott = octt && q.slotn == '0;

	for (genvar g = 0; g < N_TMR; g++) begin : g_tick
		assign tt[g] = q.gran[g] ? slott : octt;
		assign texp[g] = q.tmr[g] == '0;
	end

	// Sort and contention delay functions
	assign cs = {apair(q.sta, q.ccnt), 1'b0};
	assign cont = ~apair(q.sta, q.kcnt);
	assign idle = q.low ? IDLE_LOW : IDLE_OTH;
	assign rdly = !q.under;
	assign clen = 16'(cs) * 16'(q.slot);
	assign fcv = q.fc;

	////////////////////////////////////////////////////////////////////////////
	// Next state, every condition from the same present state
	always_comb begin
		d = q;
		take = 1'b0;
		tw = '0;
		sgo = 1'b0;
		cgo = 1'b0;
		ncrc = '0;
		req = wb_i.cyc && wb_i.stb;
		wr = req && wb_i.we && q.ack;
		case (wb_i.adr)
			OFF_CFG: rv = {24'h0, q.gran, 1'b0, q.omit, q.under, q.low};
			OFF_STAT: rv = {19'h0, q.fault, q.rsp, |pend_i, texp, q.heard,
				q.fault == FAULT_MAX, q.tx != TX_IDLE, q.on};
			OFF_DLY: rv = {3'h0, rdly, 1'b0, idle, 2'h0, cont, 1'b0, cs,
				3'h0, q.kcnt, 3'h0, q.ccnt};
			OFF_FC: rv = {23'h0, fcv.fid != FID_CTRL, q.fc};
			OFF_TXLEN: rv = {19'h0, q.txlen};
			OFF_ISTA: rv = {16'h0, q.ista};
			OFF_ISLOT: rv = {19'h0, q.islot};
			OFF_ISOL: rv = {24'h0, q.isol};
			OFF_IRET: rv = {29'h0, q.iret};
			OFF_IHOLD: rv = {16'h0, q.ihold};
			OFF_IRMT: rv = {11'h0, q.irmt};
			OFF_IRING: rv = {31'h0, q.iring};
			OFF_OP1: rv = {3'h0, q.slot, q.sta};
			OFF_OP2: rv = {4'h0, q.ring, q.ret, q.sol, q.hold};
			default: rv = '0;
		endcase
		for (int i = 0; i < N_TMR; i++) begin
			if (wb_i.adr == OFF_ITRT0 + 8'(4 * i)) begin
				rv = {11'h0, q.itrt[i]};
			end
			if (wb_i.adr == OFF_TMR0 + 8'(4 * i)) begin
				rv = {11'h0, q.tmr[i]};
			end
		end
		wd = bmerge(rv, wb_i.dat, wb_i.sel);

		// Bus answer one cycle after the request
		d.ack = req && !q.ack;
		if (req && !q.ack) begin
			d.rdat = rv;
		end

		// Receive path, own frames masked
		d.r1 = phy_rx_i;
		d.r2 = q.r1;
		d.r3 = q.r2;
		// Own symbols still in the synchroniser after the frame ends
		d.own = {q.own[1:0], q.tx != TX_IDLE};
		if (req && !wb_i.we && q.ack && wb_i.adr == OFF_STAT) begin
			d.heard = 1'b0;
		end
		if (q.r2 == q.r3 && q.r3 != SYM_SIL && q.tx == TX_IDLE && q.own == '0) begin
			d.heard = 1'b1;
		end

		// Tick dividers
		d.div = symt ? '0 : q.div + 8'h1;
		if (symt) begin
			d.symn = q.symn + 3'h1;
		end
		if (octt) begin
			d.slotn = slott ? q.slot - 13'h1 : q.slotn - 13'h1;
		end

		// Down-counting timers
		for (int i = 0; i < N_TMR; i++) begin
			if (tt[i] && !texp[i]) begin
				d.tmr[i] = q.tmr[i] - 21'h1;
			end
		end

		// Register writes
		if (wr) begin
			case (wb_i.adr)
				OFF_CTRL: begin
					if (wd[CB_INIT] && !q.on) begin
						d.on = 1'b1;
						d.sta = q.ista;
						d.slot = q.islot;
						d.sol = q.isol;
						d.ret = q.iret;
						d.hold = q.ihold;
						d.trt = q.itrt;
						d.rmt = q.irmt;
						d.ring = q.iring;
						d.slotn = '0;
					end
					if (wd[CB_OFF]) begin
						d.on = 1'b0;
					end
					sgo = wd[CB_SEND];
					cgo = wd[CB_CLAIM];
					if (wd[CB_FINC] && q.fault != FAULT_MAX) begin
						d.fault = q.fault + 3'h1;
					end
					if (wd[CB_FCLR]) begin
						d.fault = '0;
					end
					if (wd[CB_PCLR]) begin
						d.ccnt = '0;
						d.kcnt = '0;
					end
					if (wd[CB_KINC] && q.kcnt != PASS_MAX) begin
						d.kcnt = q.kcnt + 5'h1;
					end
					if (wd[CB_RPOP]) begin
						d.rsp = 1'b0;
					end
				end
				OFF_CFG: begin
					d.low = wd[CF_LOW];
					d.under = wd[CF_UNDER];
					d.omit = wd[CF_OMIT];
					d.gran = wd[CF_GRAN +: N_TMR];
				end
				OFF_FC: d.fc = wd[7:0];
				OFF_TXLEN: d.txlen = wd[12:0] > MAX_DU ? MAX_DU : wd[12:0];
				OFF_ISTA: d.ista = wd[15:0];
				OFF_ISLOT: d.islot = wd[12:0] < SLOT_MIN ? SLOT_MIN : wd[12:0];
				OFF_ISOL: d.isol = wd[7:0] < SOL_MIN ? SOL_MIN : wd[7:0];
				OFF_IRET: d.iret = wd[2:0];
				OFF_IHOLD: d.ihold = wd[15:0];
				OFF_IRMT: d.irmt = wd[20:0];
				OFF_IRING: d.iring = wd[0];
				default: ;
			endcase
			// Rotation targets for classes -2, 0, 2, 4 by index
			for (int i = 0; i < N_TMR; i++) begin
				if (wb_i.adr == OFF_ITRT0 + 8'(4 * i)) begin
					d.itrt[i] = wd[20:0];
				end
				if (wb_i.adr == OFF_TMR0 + 8'(4 * i)) begin
					tw[i] = 1'b1;
					if (wd[TB_TRT]) begin
						d.tmr[i] = q.trt[i];
					end else if (wd[TB_RMT]) begin
						d.tmr[i] = q.rmt;
					end else begin
						d.tmr[i] = wd[20:0];
					end
				end
			end
		end

		// Response queue, push wins over pop
		if (rsp_push_i) begin
			d.rsp = 1'b1;
		end

		////////////////////////////////////////////////////////////////////////
		// Transmitter, one symbol per symbol time
		case (q.tx)
			TX_IDLE: begin
				d.sym = SYM_SIL;
				if ((sgo || cgo) && q.on) begin
					d.tx = TX_FC;
					d.sh = q.fc;
					d.bitn = '0;
					d.crc = '1;
					d.claim = cgo;
					d.left = cgo ? clen : 16'(q.txlen);
					if (cgo && q.ccnt != PASS_MAX) begin
						d.ccnt = q.ccnt + 5'h1;
					end
				end
			end
			TX_FC, TX_BODY, TX_FCS: begin
				if (symt && q.last) begin
					d.tx = TX_IDLE;
					d.sym = SYM_SIL;
					d.last = 1'b0;
				end else if (symt) begin
					d.sym = q.sh[0] ? SYM_ONE : SYM_ZERO;
					d.sh = q.sh >> 1;
					d.bitn = q.bitn + 3'h1;
					ncrc = {q.crc[30:0], 1'b0} ^ ((q.sh[0] ^ q.crc[31]) ? CRC_POLY : '0);
					if (q.tx != TX_FCS) begin
						d.crc = ncrc;
					end
					if (q.bitn == 3'(OCT_SYMS - 1)) begin
						if (q.tx != TX_FCS && q.left != '0) begin
							d.tx = TX_BODY;
							d.left = q.left - 16'h1;
							d.sh = q.claim ? CLAIM_FILL : tx_oct_i;
							take = !q.claim;
						end else if (q.tx != TX_FCS && !(q.omit && !q.claim)) begin
							d.tx = TX_FCS;
							d.left = 16'(FCS_OCT - 1);
							d.crc = ~ncrc;
							d.sh = ~ncrc[31:24];
						end else if (q.tx == TX_FCS && q.left != '0) begin
							d.left = q.left - 16'h1;
							d.crc = {q.crc[23:0], 8'h0};
							d.sh = q.crc[23:16];
						end else begin
							// Last symbol stands a full symbol time
							d.last = 1'b1;
						end
					end
				end
			end
			default: d.tx = TX_IDLE;
		endcase

		// Fault limit takes the station offline
		if (q.fault == FAULT_MAX) begin
			d.on = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= RST;
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign wb_dat_o = q.rdat;
	assign wb_ack_o = q.ack;
	assign tx_take_o = take && ce_i;
	assign rsp_full_o = q.rsp;
	assign phy_tx_o = q.sym;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_init_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(q.on) |-> q.sta == $past(q.ista) && q.slot == $past(q.islot))
		else $error("station address not loaded at init");

	a_init_rest: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(q.on) |-> q.ret == $past(q.iret) && q.rmt == $past(q.irmt)
			&& q.trt == $past(q.itrt) && q.ring == $past(q.iring))
		else $error("parameters not loaded at init");

	a_tmr_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		texp[0] && !tw[0] |=> texp[0])
		else $error("expired timer left zero without a start");

	a_tmr_step: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && tt[0] && !texp[0] && !tw[0] |=> q.tmr[0] == $past(q.tmr[0]) - 21'h1)
		else $error("timer did not step down on its tick");

	a_fault_off: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && q.fault == FAULT_MAX |=> !q.on)
		else $error("station online with fault limit reached");

	a_slot_min: assert property (@(posedge clk_i) disable iff (rst_i)
		q.islot >= SLOT_MIN && q.slot >= SLOT_MIN)
		else $error("slot time below one octet");

	a_sol_min: assert property (@(posedge clk_i) disable iff (rst_i)
		q.isol >= SOL_MIN)
		else $error("solicit count below minimum");

	a_own_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		q.tx != TX_IDLE && !q.heard |=> !q.heard)
		else $error("own transmission counted as heard");

	a_claim_step: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && cgo && q.on && q.tx == TX_IDLE && q.ccnt != PASS_MAX
			|=> q.ccnt == $past(q.ccnt) + 5'h1 && q.left == $past(clen))
		else $error("claim pass count or length wrong");

	a_len_cap: assert property (@(posedge clk_i) disable iff (rst_i)
		q.txlen <= MAX_DU && q.ccnt <= PASS_MAX && q.kcnt <= PASS_MAX)
		else $error("length or pass count over limit");

	a_sil_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && q.tx == TX_IDLE ##1 ce_i && q.tx == TX_IDLE |=> phy_tx_o == SYM_SIL)
		else $error("line not silent while idle");

endmodule

/* File: logic/tbac_pkg.sv */
// Constants, register map and carrier types of the token bus access core.
// Assumes a 50 MHz station clock and a 10 Mb/s network symbol rate.
package tbac_pkg;
	// Station clock and symbol timing
	localparam int CLK_NS = 20;
	localparam int SYMBOL_NS = 100;
	localparam int SYM_CLKS = SYMBOL_NS / CLK_NS;
	localparam logic [7:0] SYM_LAST = 8'(SYM_CLKS - 1);
	localparam int OCT_SYMS = 8;
	// Protocol constants
	localparam int ADDR_LEN = 16;
	localparam int ADDR_PAIRS = ADDR_LEN / 2;
	localparam logic [4:0] PASS_MAX = 5'(ADDR_LEN / 2 + 1);
	localparam int MAX_FRAME = 8191;
	localparam logic [12:0] MAX_DU = 13'(MAX_FRAME - (5 + 2 * ADDR_LEN / 8));
	localparam int MAX_ACC_CLASS = 6;
	localparam int RING_MAINT_CLASS = -2;
	localparam logic [2:0] FAULT_MAX = 3'h7;
	localparam logic [12:0] SLOT_MIN = 13'h0001;
	localparam logic [7:0] SOL_MIN = 8'h10;
	localparam logic [2:0] RETRY_RST = 3'h3;
	localparam logic [2:0] IDLE_LOW = 3'h6;
	localparam logic [2:0] IDLE_OTH = 3'h7;
	localparam int N_TMR = 4;
	localparam int FCS_OCT = 4;
	localparam logic [31:0] CRC_POLY = 32'h04c11db7;
	localparam logic [1:0] FID_CTRL = 2'h0;
	localparam logic [7:0] CLAIM_FILL = 8'hff;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CFG = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_DLY = 8'h0c;
	localparam logic [7:0] OFF_FC = 8'h10;
	localparam logic [7:0] OFF_TXLEN = 8'h14;
	localparam logic [7:0] OFF_ISTA = 8'h18;
	localparam logic [7:0] OFF_ISLOT = 8'h1c;
	localparam logic [7:0] OFF_ISOL = 8'h20;
	localparam logic [7:0] OFF_IRET = 8'h24;
	localparam logic [7:0] OFF_IHOLD = 8'h28;
	localparam logic [7:0] OFF_IRMT = 8'h2c;
	localparam logic [7:0] OFF_IRING = 8'h30;
	localparam logic [7:0] OFF_ITRT0 = 8'h34;
	localparam logic [7:0] OFF_TMR0 = 8'h44;
	localparam logic [7:0] OFF_OP1 = 8'h54;
	localparam logic [7:0] OFF_OP2 = 8'h58;
	// Control, config and timer-start bit positions
	localparam int CB_INIT = 0;
	localparam int CB_OFF = 1;
	localparam int CB_SEND = 2;
	localparam int CB_CLAIM = 3;
	localparam int CB_FINC = 4;
	localparam int CB_FCLR = 5;
	localparam int CB_PCLR = 6;
	localparam int CB_KINC = 7;
	localparam int CB_RPOP = 8;
	localparam int CF_LOW = 0;
	localparam int CF_UNDER = 1;
	localparam int CF_OMIT = 2;
	localparam int CF_GRAN = 4;
	localparam int TB_RMT = 30;
	localparam int TB_TRT = 31;
	// Line symbols toward the physical layer
	typedef enum logic [2:0] {
		SYM_ZERO = 3'h0,
		SYM_ONE = 3'h1,
		SYM_NDATA = 3'h2,
		SYM_PAD = 3'h3,
		SYM_BAD = 3'h4,
		SYM_SIL = 3'h5
	} tbac_sym_e;
	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_FC = 4'h2,
		TX_BODY = 4'h4,
		TX_FCS = 4'h8
	} tbac_tx_e;
	// Frame control octet
	typedef struct packed {
		logic [2:0] pri;
		logic [2:0] act;
		logic [1:0] fid;
	} tbac_fc_s;
	// Classic Wishbone request
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} tbac_wb_s;
endpackage

/* File: sim/tbac_phy_model.sv */
// Physical-layer side model: listens to transmit symbols, echoes or injects traffic.
// Assumes each symbol stands five station clocks, with silence between frames.
`timescale 1ns/1ps
module tbac_phy_model
	import tbac_pkg::*;
(
	// Clock and mode
	input wire logic clk_i,
	input wire logic echo_i,
	input wire logic foreign_i,
	// Line
	input wire tbac_sym_e phy_tx_i,
	output logic [2:0] phy_rx_o,
	// Observed symbols
	output logic bit_vld_o,
	output logic bit_o,
	output logic [9:0] len_o,
	output logic done_o
);
	int ph;
	logic act;

	////////////////////////////////////////////////////////////////////////////////
	// Line: own echo, foreign pad-idle or silence
	assign phy_rx_o = foreign_i ? 3'(SYM_PAD) : (echo_i ? 3'(phy_tx_i) : 3'(SYM_SIL));

	initial begin
		ph = 0;
		act = 1'b0;
		bit_vld_o = 1'b0;
		bit_o = 1'b0;
		len_o = 10'h0;
		done_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mid-symbol sampling, one symbol per five clocks
	always @(posedge clk_i) begin
		bit_vld_o <= 1'b0;
		done_o <= 1'b0;
		if (!act) begin
			if (phy_tx_i != SYM_SIL) begin
				act <= 1'b1;
				ph <= 1;
				len_o <= 10'h0;
			end
		end else begin
			ph <= (ph == SYM_CLKS - 1) ? 0 : ph + 1;
			if (ph == 2) begin
				if (phy_tx_i == SYM_SIL) begin
					act <= 1'b0;
					done_o <= 1'b1;
				end else begin
					bit_vld_o <= 1'b1;
					bit_o <= (phy_tx_i == SYM_ONE);
					len_o <= len_o + 10'h1;
				end
			end
		end
	end
endmodule

/* File: sim/tbac_tb.sv */
// Self-checking bench for the token bus access core.
// Assumes a one-cycle bus answer and the physical-layer model beside it.
`timescale 1ns/1ps
module tb;
	import tbac_pkg::*;
	typedef struct {string nm; logic [31:0] v; logic [31:0] m;} tbac_exp_s;
	localparam logic [31:0] ALL = 32'hffffffff;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	tbac_wb_s wb = '0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, tx_take_o, rsp_full_o, bvld, bval, fdone;
	logic rsp_push = 1'b0;
	logic ce = 1'b1;
	logic [31:0] crc;
	logic echo = 1'b0;
	logic foreign = 1'b0;
	logic [3:0] pend = 4'h0;
	logic [7:0] body [4] = '{8'h0, 8'h0, 8'h0, 8'h0};
	logic [1:0] bidx = 2'h0;
	logic [2:0] phy_rx;
	tbac_sym_e phy_tx;
	logic [9:0] flen;
	int errors = 0;
	int comparisons = 0;
	tbac_exp_s rq[$];
	tbac_exp_s e;
	logic bq[$];
	logic [15:0] sta, hold;
	logic [7:0] sol, fc;
	logic [2:0] ret;
	logic [20:0] rmt, trt;
	int pair;

	always #10 clk_i = ~clk_i;

	tbac_core DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_i(wb), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .pend_i(pend), .rsp_push_i(rsp_push), .tx_oct_i(body[bidx]),
		.tx_take_o(tx_take_o), .rsp_full_o(rsp_full_o), .phy_rx_i(phy_rx), .phy_tx_o(phy_tx));
	tbac_phy_model PHY (.clk_i(clk_i), .echo_i(echo), .foreign_i(foreign), .phy_tx_i(phy_tx),
		.phy_rx_o(phy_rx), .bit_vld_o(bvld), .bit_o(bval), .len_o(flen), .done_o(fdone));

	////////////////////////////////////////////////////////////////////////////////
	// Compare, verdict, bus tasks
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 40);
		wb <= '0;
		if (n >= 40) begin
			errors++;
			report_and_stop();
		end
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] v,
		input logic [31:0] m);
		rq.push_back('{nm, v, m});
		bus(1'b0, a, 32'h0);
	endtask
	// Expected line bits of one octet, LSB first, running checksum
	task automatic push_oct(input logic [7:0] o);
		for (int b = 0; b < 8; b++) begin
			bq.push_back(o[b]);
			crc = {crc[30:0], 1'b0} ^ ((o[b] ^ crc[31]) ? CRC_POLY : 32'h0);
		end
	endtask
	task automatic frame(input int bits);
		int n;
		n = 0;
		while (fdone !== 1'b1 && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		check("frame length", 32'(flen), 32'(bits));
		check("bits left", 32'(bq.size()), 32'h0);
		if (n >= 2000) begin
			errors++;
			report_and_stop();
		end
	endtask
	function automatic logic [31:0] dly(input int cl, input int ct, input logic lo, input logic un);
		int pc, pk;
		pc = cl < 8 ? int'(sta[15 - 2 * cl -: 2]) : 0;
		pk = ct < 8 ? int'(sta[15 - 2 * ct -: 2]) : 0;
		dly = 32'(cl) | (32'(ct) << 8) | (32'(2 * pc) << 16) | (32'(3 - pk) << 20)
			| ((lo ? 32'h6 : 32'h7) << 24) | (un ? 32'h0 : 32'h10000000);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Result watcher
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb.we === 1'b0 && rq.size() > 0) begin
			e = rq.pop_front();
			check(e.nm, wb_dat_o & e.m, e.v & e.m);
		end
		if (bvld === 1'b1 && bq.size() > 0) begin
			check("line bit", 32'(bval), 32'(bq.pop_front()));
		end
		if (tx_take_o === 1'b1) begin
			bidx <= bidx + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(32'h15dd));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rd("islot", OFF_ISLOT, 32'h1, ALL);
		rd("isol", OFF_ISOL, 32'h10, ALL);
		rd("iret", OFF_IRET, 32'h3, ALL);
		rd("unmapped", 8'hfc, 32'h0, ALL);
		rd("offline", OFF_STAT, 32'h0, 32'h1);
		$display("test reset done");
		sta = 16'($urandom);
		sol = 8'h10 + 8'($urandom % 240);
		ret = 3'($urandom);
		hold = 16'($urandom);
		rmt = {17'($urandom), 4'h8};
		trt = {17'($urandom), 4'h8};
		wr(OFF_ISLOT, 32'h0);
		rd("slot floor", OFF_ISLOT, 32'h1, ALL);
		wr(OFF_ISOL, 32'h5);
		rd("solicit floor", OFF_ISOL, 32'h10, ALL);
		wr(OFF_ISTA, 32'(sta));
		wr(OFF_ISOL, 32'(sol));
		wr(OFF_IRET, 32'(ret));
		wr(OFF_IHOLD, 32'(hold));
		wr(OFF_IRMT, 32'(rmt));
		wr(OFF_IRING, 32'h1);
		wr(OFF_ITRT0, 32'(trt));
		wr(OFF_CTRL, 32'h1);
		rd("op1", OFF_OP1, {3'h0, 13'h1, sta}, ALL);
		rd("op2", OFF_OP2, {4'h0, 1'b1, ret, sol, hold}, ALL);
		wr(OFF_TMR0, 32'h80000000);
		rd("trt timer", OFF_TMR0, 32'(trt), 32'h1ffff0);
		wr(OFF_TMR0 + 8'h4, 32'h40000000);
		rd("rmt timer", OFF_TMR0 + 8'h4, 32'(rmt), 32'h1ffff0);
		rd("online", OFF_STAT, 32'h1, 32'h1);
		$display("test init done");
		wr(OFF_CFG, 32'h3);
		for (int k = 0; k <= 10; k++) begin
			rd("sort", OFF_DLY, dly(0, k > 9 ? 9 : k, 1'b1, 1'b1), 32'h17371f1f);
			wr(OFF_CTRL, 32'h80);
		end
		wr(OFF_CFG, 32'h0);
		rd("idle resp", OFF_DLY, dly(0, 9, 1'b0, 1'b0), 32'h17000000);
		for (int f = 0; f < 4; f++) begin
			fc = {6'($urandom), 2'(f)};
			wr(OFF_FC, 32'(fc));
			rd("fc class", OFF_FC, {23'h0, f != 0, fc}, 32'h1ff);
		end
		wr(OFF_TXLEN, 32'h1fff);
		rd("du cap", OFF_TXLEN, 32'h1ff6, 32'h1fff);
		$display("test fields done");
		body[0] <= 8'($urandom);
		body[1] <= 8'($urandom);
		bidx <= 2'h0;
		wr(OFF_TXLEN, 32'h2);
		wr(OFF_CFG, 32'h4);
		push_oct(fc);
		push_oct(body[0]);
		push_oct(body[1]);
		echo <= 1'b1;
		wr(OFF_CTRL, 32'h4);
		frame(24);
		echo <= 1'b0;
		rd("own echo", OFF_STAT, 32'h0, 32'h8);
		foreign <= 1'b1;
		repeat (20) @(posedge clk_i);
		foreign <= 1'b0;
		repeat (5) @(posedge clk_i);
		rd("heard", OFF_STAT, 32'h8, 32'h8);
		rd("heard clr", OFF_STAT, 32'h0, 32'h8);
		wr(OFF_CTRL, 32'h40);
		pair = int'(sta[15:14]);
		crc = 32'hffffffff;
		push_oct(fc);
		for (int i = 0; i < 2 * pair; i++) begin
			push_oct(CLAIM_FILL);
		end
		crc = ~crc;
		for (int i = 0; i < 32; i++) begin
			bq.push_back(crc[24 - 8 * (i / 8) + i % 8]);
		end
		wr(OFF_CTRL, 32'h8);
		frame(8 * (5 + 2 * pair));
		rd("claim pass", OFF_DLY, 32'h1, 32'h1f);
		$display("test transmit done");
		wr(OFF_TMR0 + 8'h8, 32'h3);
		rd("tmr start", OFF_TMR0 + 8'h8, 32'h2, 32'hfffffffe);
		ce <= 1'b0;
		repeat (200) @(posedge clk_i);
		ce <= 1'b1;
		rd("tmr frozen", OFF_TMR0 + 8'h8, 32'h2, 32'hfffffffe);
		repeat (200) @(posedge clk_i);
		rd("tmr zero", OFF_TMR0 + 8'h8, 32'h0, ALL);
		rd("expired", OFF_STAT, 32'hc0, 32'hf0);
		pend <= 4'($urandom) | 4'h1;
		rsp_push <= 1'b1;
		@(posedge clk_i);
		rsp_push <= 1'b0;
		rd("pend full", OFF_STAT, 32'h300, 32'h300);
		check("full pin", 32'(rsp_full_o), 32'h1);
		wr(OFF_CTRL, 32'h100);
		rd("popped", OFF_STAT, 32'h100, 32'h300);
		$display("test timers done");
		repeat (7) wr(OFF_CTRL, 32'h10);
		rd("fault", OFF_STAT, 32'h1c04, 32'h1c05);
		wr(OFF_CTRL, 32'h1);
		rd("init refused", OFF_STAT, 32'h0, 32'h1);
		wr(OFF_CTRL, 32'h20);
		wr(OFF_CTRL, 32'h1);
		rd("reinit", OFF_STAT, 32'h1, 32'h1c05);
		$display("test fault done");
		report_and_stop();
	end
endmodule
